// File: rtl/board_regs_pkg.sv
// shared constants, field layouts and carriers for the board register bank
package board_regs_pkg;
	// register byte offsets on the local bus
	localparam logic [7:0] OFS_BOARD_CTRL = 8'h00;
	localparam logic [7:0] OFS_INPUT_PORT = 8'h08;
	localparam logic [7:0] OFS_OPTIONS = 8'h24;
	localparam logic [7:0] OFS_ALT_IO = 8'h34;
	// board control word fields
	localparam int IRQ_SEL_LSB = 8;
	localparam int IRQ_PEND_BIT = 11;
	localparam int EXT_SYNC_ACCEPT_BIT = 12;
	localparam logic [31:0] BOARD_CTRL_RST = 32'h0000_0000;
	// input port configuration fields
	localparam int COUPLE_BIT = 0;
	localparam int EXCITE_BIT = 1;
	localparam logic [1:0] INPUT_PORT_RST = 2'h0;
	// option word fields
	localparam int REV_LSB = 0;
	localparam int STATUS_LSB = 12;
	localparam int CHAN_LSB = 16;
	localparam int FILT_LSB = 18;
	localparam int CUTOFF_LSB = 20;
	localparam int EXCUR_LSB = 22;
	// alternate clock/sync direction fields
	localparam int CLK_MODE_LSB = 0;
	localparam int SYNC_MODE_LSB = 2;
	localparam logic [3:0] ALT_IO_RST = 4'h0;
	localparam logic [1:0] AUX_INACTIVE = 2'h0;
	localparam logic [1:0] AUX_INPUT = 2'h1;
	// interrupt event selector codes
	localparam logic [2:0] EV_INIT = 3'h0;
	localparam logic [2:0] EV_CAL = 3'h1;
	localparam logic [2:0] EV_SETTLED = 3'h2;
	localparam logic [2:0] EV_THR_UP = 3'h3;
	localparam logic [2:0] EV_THR_DN = 3'h4;
	localparam logic [2:0] EV_BURST = 3'h5;
	// clock source code meaning external sample clock
	localparam logic [3:0] EXT_CLK_SRC_CODE = 4'h4;
	// settling hold of the inputs-settled flag
	localparam longint SETTLE_TIME_MS = 5000;
	localparam longint MCLK_KHZ = 200000;
	localparam longint SETTLE_CYCLES = SETTLE_TIME_MS * MCLK_KHZ;
	// local bus request carrier
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} lb_req_t;
	// status conditions from the acquisition engines
	typedef struct packed {
		logic init_done;
		logic autocal_done;
		logic engine_ready;
		logic buf_threshold;
		logic burst_done;
	} board_events_t;
endpackage

// File: rtl/board_irq_aux_io_regs.sv
// local controller register bank: interrupt request, options word, alternate clock/sync i/o, input port config
`timescale 1ns/1ps
`default_nettype none
module board_irq_aux_io_regs #(
	parameter logic [11:0] FW_REVISION = 12'h001,
	parameter logic [3:0] STATUS_FLAGS = 4'h0,
	parameter logic [1:0] CHAN_CODE = 2'h0,
	parameter logic [1:0] FILTER_CODE = 2'h0,
	parameter logic [1:0] CUTOFF_CODE = 2'h0,
	parameter logic [1:0] EXCUR_CODE = 2'h0,
	parameter logic [31:0] SETTLE_CNT = 32'(board_regs_pkg::SETTLE_CYCLES)
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire board_regs_pkg::lb_req_t lb_req,
	output logic [31:0] lb_rdata_r,
	output logic lb_rvalid_r,
	input wire board_regs_pkg::board_events_t events,
	input wire logic irq_emul_en,
	output logic local_irq_r,
	output logic host_irq_r,
	output logic inputs_settled_r,
	output logic direct_coupling_select_r,
	output logic excitation_on_r,
	input wire logic [3:0] clock_source_code,
	input wire logic clock_io_sig,
	input wire logic sync_io_sig,
	input wire logic connector_clock_in,
	input wire logic connector_sync_in,
	input wire logic aux_clk_in,
	output logic aux_clk_out_r,
	output logic aux_clk_oe_r,
	input wire logic aux_sync_in,
	output logic aux_sync_out_r,
	output logic aux_sync_oe_r,
	output logic sel_clock_in_r,
	output logic sel_sync_in_r
);
	import board_regs_pkg::*;

	logic [2:0] irq_sel_r;
	logic ext_sync_accept_r;
	logic [1:0] clk_mode_r;
	logic [1:0] sync_mode_r;
	logic [2:0] sel_prev_r;
	logic cond_prev_r;
	logic init_prev_r;
	logic cond_now;
	logic irq_event;
	logic wr_ctrl;
	logic wr_port;
	logic [31:0] settle_cnt_r;
	logic settle_start;
	logic [1:0] clk_sync_r;
	logic [1:0] sync_sync_r;
	logic [1:0] cclk_sync_r;
	logic [1:0] csync_sync_r;
	logic aux_ok;
	logic [31:0] rdata_nxt;

	// true when the aux mode field selects input and the other gates agree
	function automatic logic aux_in_active(input logic [1:0] mode, input logic ok);
		return (mode == AUX_INPUT) && ok;
	endfunction

	assign wr_ctrl = lb_req.wr && (lb_req.addr == OFS_BOARD_CTRL);
	assign wr_port = lb_req.wr && (lb_req.addr == OFS_INPUT_PORT);

	// condition picked by the selector; reserved codes give no condition
	always_comb begin
		unique case (irq_sel_r)
			EV_INIT: cond_now = events.init_done;
			EV_CAL: cond_now = events.autocal_done;
			EV_SETTLED: cond_now = inputs_settled_r;
			EV_THR_UP: cond_now = events.buf_threshold;
			EV_THR_DN: cond_now = !events.buf_threshold;
			EV_BURST: cond_now = events.burst_done;
			default: cond_now = 1'b0;
		endcase
	end

	// rising edge of the condition while the same code stays selected, or init end
	assign irq_event = (cond_now && !cond_prev_r && (sel_prev_r == irq_sel_r))
		|| (events.init_done && !init_prev_r);

	// edge detector history
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cond_prev_r <= 1'b0;
			sel_prev_r <= EV_INIT;
			init_prev_r <= 1'b0;
		end else if (ce) begin
			cond_prev_r <= cond_now;
			sel_prev_r <= irq_sel_r;
			init_prev_r <= events.init_done;
		end
	end

	// board control word fields written by the host
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_sel_r <= BOARD_CTRL_RST[IRQ_SEL_LSB +: 3];
			ext_sync_accept_r <= BOARD_CTRL_RST[EXT_SYNC_ACCEPT_BIT];
		end else if (ce && wr_ctrl) begin
			irq_sel_r <= lb_req.wdata[IRQ_SEL_LSB +: 3];
			ext_sync_accept_r <= lb_req.wdata[EXT_SYNC_ACCEPT_BIT];
		end
	end

	// pending flag: event sets, written zero clears, set wins over clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			local_irq_r <= BOARD_CTRL_RST[IRQ_PEND_BIT];
		end else if (ce) begin
			if (irq_event) begin
				local_irq_r <= 1'b1;
			end else if (wr_ctrl && !lb_req.wdata[IRQ_PEND_BIT]) begin
				local_irq_r <= 1'b0;
			end
		end
	end

	// host interrupt gated by the adapter's emulation enable
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			host_irq_r <= 1'b0;
		end else if (ce) begin
			host_irq_r <= local_irq_r && irq_emul_en;
		end
	end

	// input port configuration: coupling and excitation
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			direct_coupling_select_r <= INPUT_PORT_RST[COUPLE_BIT];
			excitation_on_r <= INPUT_PORT_RST[EXCITE_BIT];
		end else if (ce && wr_port) begin
			direct_coupling_select_r <= lb_req.wdata[COUPLE_BIT];
			excitation_on_r <= lb_req.wdata[EXCITE_BIT];
		end
	end

	// settling hold starts on a switch to ac coupling or excitation turned on
	assign settle_start = wr_port && ((direct_coupling_select_r && !lb_req.wdata[COUPLE_BIT])
		|| (!excitation_on_r && lb_req.wdata[EXCITE_BIT]));

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			settle_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (settle_start) begin
				settle_cnt_r <= SETTLE_CNT;
			end else if (settle_cnt_r != 32'h0000_0000) begin
				settle_cnt_r <= settle_cnt_r - 32'h0000_0001;
			end
		end
	end

	// settled flag low while the hold runs or the engine is not ready
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			inputs_settled_r <= 1'b0;
		end else if (ce) begin
			inputs_settled_r <= events.engine_ready && !settle_start
				&& (settle_cnt_r <= 32'h0000_0001);
		end
	end

	// alternate clock/sync direction register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_mode_r <= ALT_IO_RST[CLK_MODE_LSB +: 2];
			sync_mode_r <= ALT_IO_RST[SYNC_MODE_LSB +: 2];
		end else if (ce && lb_req.wr && (lb_req.addr == OFS_ALT_IO)) begin
			clk_mode_r <= lb_req.wdata[CLK_MODE_LSB +: 2];
			sync_mode_r <= lb_req.wdata[SYNC_MODE_LSB +: 2];
		end
	end

	// two-stage synchronisers for the pin inputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_sync_r <= 2'h0;
			sync_sync_r <= 2'h0;
			cclk_sync_r <= 2'h0;
			csync_sync_r <= 2'h0;
		end else if (ce) begin
			clk_sync_r <= {clk_sync_r[0], aux_clk_in};
			sync_sync_r <= {sync_sync_r[0], aux_sync_in};
			cclk_sync_r <= {cclk_sync_r[0], connector_clock_in};
			csync_sync_r <= {csync_sync_r[0], connector_sync_in};
		end
	end

	assign aux_ok = (clock_source_code == EXT_CLK_SRC_CODE) && ext_sync_accept_r;

	// source selection and aux output drive
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sel_clock_in_r <= 1'b0;
			sel_sync_in_r <= 1'b0;
			aux_clk_out_r <= 1'b0;
			aux_clk_oe_r <= 1'b0;
			aux_sync_out_r <= 1'b0;
			aux_sync_oe_r <= 1'b0;
		end else if (ce) begin
			sel_clock_in_r <= aux_in_active(clk_mode_r, aux_ok) ? clk_sync_r[1] : cclk_sync_r[1];
			sel_sync_in_r <= aux_in_active(sync_mode_r, aux_ok) ? sync_sync_r[1] : csync_sync_r[1];
			aux_clk_oe_r <= clk_mode_r[1];
			aux_sync_oe_r <= sync_mode_r[1];
			aux_clk_out_r <= clock_io_sig;
			aux_sync_out_r <= sync_io_sig;
		end
	end

	// read multiplexer; unmapped offsets read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (lb_req.addr)
			OFS_BOARD_CTRL: begin
				rdata_nxt[IRQ_SEL_LSB +: 3] = irq_sel_r;
				rdata_nxt[IRQ_PEND_BIT] = local_irq_r;
				rdata_nxt[EXT_SYNC_ACCEPT_BIT] = ext_sync_accept_r;
			end
			OFS_INPUT_PORT: begin
				rdata_nxt[COUPLE_BIT] = direct_coupling_select_r;
				rdata_nxt[EXCITE_BIT] = excitation_on_r;
			end
			OFS_OPTIONS: begin
				rdata_nxt[REV_LSB +: 12] = FW_REVISION;
				rdata_nxt[STATUS_LSB +: 4] = STATUS_FLAGS;
				rdata_nxt[CHAN_LSB +: 2] = CHAN_CODE;
				rdata_nxt[FILT_LSB +: 2] = FILTER_CODE;
				rdata_nxt[CUTOFF_LSB +: 2] = CUTOFF_CODE;
				rdata_nxt[EXCUR_LSB +: 2] = EXCUR_CODE;
			end
			OFS_ALT_IO: begin
				rdata_nxt[CLK_MODE_LSB +: 2] = clk_mode_r;
				rdata_nxt[SYNC_MODE_LSB +: 2] = sync_mode_r;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lb_rdata_r <= 32'h0000_0000;
			lb_rvalid_r <= 1'b0;
		end else if (ce) begin
			lb_rvalid_r <= lb_req.rd;
			if (lb_req.rd) begin
				lb_rdata_r <= rdata_nxt;
			end
		end
	end

	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	irq_raise_a: assert property (ce && irq_event |=> local_irq_r)
		else $error("event did not set pending flag");
	irq_hold_a: assert property (ce && local_irq_r && !(wr_ctrl && !lb_req.wdata[IRQ_PEND_BIT]) |=> local_irq_r)
		else $error("pending flag dropped without a clear");
	init_raise_a: assert property (ce && $rose(events.init_done) |=> local_irq_r)
		else $error("init end did not raise request");
	held_cond_a: assert property (ce && !irq_event && !local_irq_r && !wr_ctrl |=> !local_irq_r)
		else $error("request without an edge");
	host_gate_a: assert property (ce && !irq_emul_en |=> !host_irq_r)
		else $error("host interrupt without emulation");
	one_ignored_a: assert property (ce && wr_ctrl && lb_req.wdata[IRQ_PEND_BIT] && !local_irq_r && !irq_event
		|=> !local_irq_r)
		else $error("written one set pending flag");
	settle_hold_a: assert property (ce && settle_start |=> !inputs_settled_r [*8])
		else $error("settled flag rose during hold");
	opts_read_a: assert property (ce && lb_req.rd && lb_req.addr == OFS_OPTIONS
		|=> lb_rvalid_r && lb_rdata_r[11:0] == FW_REVISION && lb_rdata_r[31:24] == 8'h00)
		else $error("options word read wrong");
	alt_upper_a: assert property (ce && lb_req.rd && lb_req.addr == OFS_ALT_IO |=> lb_rdata_r[31:4] == 28'h0)
		else $error("alt io upper bits not zero");
	aux_copy_a: assert property (ce && clk_mode_r[1] |=> aux_clk_oe_r && aux_clk_out_r == $past(clock_io_sig))
		else $error("aux clock output not copying");
	aux_gate_a: assert property (ce && !aux_ok |=> sel_clock_in_r == $past(cclk_sync_r[1]))
		else $error("aux input used without gates");

	irq_seen_c: cover property (ce && irq_event ##1 local_irq_r ##[1:20] !local_irq_r);
	settle_seen_c: cover property (ce && settle_start);
	aux_in_c: cover property (ce && aux_in_active(sync_mode_r, aux_ok));
endmodule
`default_nettype wire

// File: tb/host_adapter_model.sv
// host bus adapter model that issues local register bus cycles
`timescale 1ns/1ps
`default_nettype none
module host_adapter_model (
	input wire logic mclk,
	output var board_regs_pkg::lb_req_t lb_req,
	input wire logic [31:0] lb_rdata_r,
	input wire logic lb_rvalid_r,
	output logic irq_emul_en
);
	import board_regs_pkg::*;
	// bus idle, emulation off until asked
	initial begin
		lb_req = '0;
		irq_emul_en = 1'b0;
	end
	// one-cycle write strobe; released data is scrambled so stale values never look valid
	task automatic write_word(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1;
		lb_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		#1;
		lb_req = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask
	// one-cycle read strobe; answer sampled 1 ns after the edge that takes the strobe
	task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic v);
		@(posedge mclk);
		#1;
		lb_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~lb_req.wdata};
		@(posedge mclk);
		#1;
		lb_req.rd = 1'b0;
		d = lb_rdata_r;
		v = lb_rvalid_r;
	endtask
	// release the request by writing zero to pending while keeping the selector
	task automatic clear_pending(input logic [2:0] sel);
		write_word(OFS_BOARD_CTRL, 32'(sel) << IRQ_SEL_LSB);
	endtask
	task automatic set_emul(input logic en);
		irq_emul_en = en;
	endtask
endmodule
`default_nettype wire

// File: tb/board_irq_aux_io_regs_tb_top.sv
// self-checking bench for the board register bank
`timescale 1ns/1ps
`default_nettype none
module board_irq_aux_io_regs_tb_top;
	import board_regs_pkg::*;
	localparam int SETTLE_SIM = 20;
	logic mclk, rst_b, ce, lb_rvalid_r, irq_emul_en, local_irq_r, host_irq_r, inputs_settled_r;
	logic direct_coupling_select_r, excitation_on_r, clock_io_sig, sync_io_sig;
	logic connector_clock_in, connector_sync_in, aux_clk_in, aux_clk_out_r, aux_clk_oe_r;
	logic aux_sync_in, aux_sync_out_r, aux_sync_oe_r, sel_clock_in_r, sel_sync_in_r;
	logic [31:0] lb_rdata_r;
	logic [3:0] clock_source_code;
	lb_req_t lb_req;
	board_events_t events;
	int num_errors = 0;
	int tests_run = 0;
	board_irq_aux_io_regs #(.FW_REVISION(12'hA5C), .STATUS_FLAGS(4'h3), .CHAN_CODE(2'h1), .FILTER_CODE(2'h1),
		.CUTOFF_CODE(2'h1), .EXCUR_CODE(2'h0), .SETTLE_CNT(32'(SETTLE_SIM))) u_dut (.mclk(mclk), .rst_b(rst_b),
		.ce(ce), .lb_req(lb_req), .lb_rdata_r(lb_rdata_r), .lb_rvalid_r(lb_rvalid_r), .events(events),
		.irq_emul_en(irq_emul_en), .local_irq_r(local_irq_r), .host_irq_r(host_irq_r),
		.inputs_settled_r(inputs_settled_r), .direct_coupling_select_r(direct_coupling_select_r),
		.excitation_on_r(excitation_on_r), .clock_source_code(clock_source_code), .clock_io_sig(clock_io_sig),
		.sync_io_sig(sync_io_sig), .connector_clock_in(connector_clock_in), .connector_sync_in(connector_sync_in),
		.aux_clk_in(aux_clk_in), .aux_clk_out_r(aux_clk_out_r), .aux_clk_oe_r(aux_clk_oe_r),
		.aux_sync_in(aux_sync_in), .aux_sync_out_r(aux_sync_out_r), .aux_sync_oe_r(aux_sync_oe_r),
		.sel_clock_in_r(sel_clock_in_r), .sel_sync_in_r(sel_sync_in_r));
	host_adapter_model u_host (.mclk(mclk), .lb_req(lb_req), .lb_rdata_r(lb_rdata_r), .lb_rvalid_r(lb_rvalid_r),
		.irq_emul_en(irq_emul_en));
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic v;
		u_host.read_word(a, d, v);
		chk(v, 1);
		chk(d, exp);
	endtask
	// bounded wait for the local request
	task automatic wait_irq;
		for (int i = 0; i < 8 && local_irq_r !== 1'b1; i++) cyc(1);
	endtask
	// reset values, read-only and reserved bits, unmapped place
	task automatic t_regs;
		rd_chk(OFS_INPUT_PORT, 32'h0);
		chk(direct_coupling_select_r, 0);
		chk(excitation_on_r, 0);
		rd_chk(OFS_ALT_IO, 32'h0);
		rd_chk(OFS_OPTIONS, 32'h0015_3A5C);
		u_host.write_word(OFS_OPTIONS, 32'hFFFF_FFFF);
		rd_chk(OFS_OPTIONS, 32'h0015_3A5C);
		u_host.write_word(OFS_ALT_IO, 32'hFFFF_FFF6);
		rd_chk(OFS_ALT_IO, 32'h6);
		rd_chk(8'h10, 32'h0);
	endtask
	// end of initialization raises the request, cleared only by a written zero
	task automatic t_init_irq;
		events.init_done = 1'b1;
		wait_irq();
		chk(local_irq_r, 1);
		u_host.write_word(OFS_BOARD_CTRL, 32'h0000_0800);
		cyc(3);
		chk(local_irq_r, 1);
		u_host.clear_pending(EV_INIT);
		cyc(3);
		chk(local_irq_r, 0);
	endtask
	// one selector code: raise its condition, check request, pending, host line, hold and clear
	task automatic t_event(input logic [2:0] code);
		logic [31:0] d;
		logic v;
		logic exp;
		exp = code < 3'h6;
		u_host.set_emul(code[0]);
		if (!exp) events = '{init_done: 1'b1, default: 1'b0};
		u_host.clear_pending(code);
		cyc(3);
		chk(local_irq_r, 0);
		case (code)
			3'h1: events.autocal_done = 1'b1;
			3'h2: events.engine_ready = 1'b1;
			3'h3: events.buf_threshold = 1'b1;
			3'h4: events.buf_threshold = 1'b0;
			3'h5: events.burst_done = 1'b1;
			default: events = '1;
		endcase
		wait_irq();
		chk(local_irq_r, exp);
		cyc(1);
		chk(host_irq_r, exp & code[0]);
		cyc(6);
		chk(local_irq_r, exp);
		u_host.read_word(OFS_BOARD_CTRL, d, v);
		chk(d[IRQ_PEND_BIT], exp);
		u_host.clear_pending(code);
		cyc(5);
		chk(local_irq_r, 0);
		chk(host_irq_r, 0);
	endtask
	// coupling and excitation bits, settled flag held low after each trigger
	task automatic t_settle;
		int n;
		events.engine_ready = 1'b1;
		u_host.write_word(OFS_INPUT_PORT, 32'h1);
		cyc(4);
		chk(direct_coupling_select_r, 1);
		chk(inputs_settled_r, 1);
		u_host.write_word(OFS_INPUT_PORT, 32'h3);
		cyc(1);
		chk(excitation_on_r, 1);
		n = 0;
		while (inputs_settled_r !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= SETTLE_SIM - 2 && n <= SETTLE_SIM + 3), 1);
		u_host.write_word(OFS_INPUT_PORT, 32'h2);
		cyc(10);
		chk(direct_coupling_select_r, 0);
		chk(inputs_settled_r, 0);
		cyc(20);
		chk(inputs_settled_r, 1);
	endtask
	// aux pins as outputs copy main signals; as inputs they replace connector inputs only when gated
	task automatic t_aux;
		u_host.write_word(OFS_ALT_IO, 32'hE);
		for (int i = 0; i < 2; i++) begin
			clock_io_sig = !i[0];
			sync_io_sig = i[0];
			cyc(4);
			chk({aux_clk_oe_r, aux_clk_out_r, aux_sync_oe_r, aux_sync_out_r}, {2'h1, !i[0], 1'b1, i[0]});
		end
		u_host.write_word(OFS_ALT_IO, 32'h5);
		clock_source_code = EXT_CLK_SRC_CODE;
		connector_sync_in = 1'b1;
		aux_clk_in = 1'b1;
		u_host.write_word(OFS_BOARD_CTRL, 32'h0000_1000);
		cyc(6);
		chk({aux_clk_oe_r, aux_sync_oe_r, sel_clock_in_r, sel_sync_in_r}, 32'h2);
		u_host.write_word(OFS_BOARD_CTRL, 32'h0);
		cyc(6);
		chk({sel_clock_in_r, sel_sync_in_r}, 32'h1);
		// clock enable low: a write and pin changes must not reach any state
		ce = 1'b0;
		connector_clock_in = 1'b1;
		connector_sync_in = 1'b0;
		aux_sync_in = 1'b1;
		u_host.write_word(OFS_ALT_IO, 32'h0);
		cyc(4);
		chk({sel_clock_in_r, sel_sync_in_r}, 32'h1);
		ce = 1'b1;
		rd_chk(OFS_ALT_IO, 32'h5);
		cyc(4);
		chk({sel_clock_in_r, sel_sync_in_r}, 32'h2);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
	initial begin
		{rst_b, events, clock_source_code, clock_io_sig, sync_io_sig} = '0;
		{connector_clock_in, connector_sync_in, aux_clk_in, aux_sync_in} = '0;
		ce = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		t_regs();
		t_init_irq();
		for (int c = 1; c < 8; c++) t_event(3'(c));
		t_settle();
		t_aux();
		summarize();
	end
endmodule
`default_nettype wire
